// [rfat_pkg.sv]
// Purpose: shared types and constants for the register field access bank
// Assumes: one register word of RFAT_DW bits, per-bit access type codes
// Notes:   type codes are packed RFAT_TW bits per register bit, bit 0 lowest
package rfat_pkg;

  localparam int RFAT_DW = 32;
  localparam int RFAT_TW = 3;

  // field access kinds, one code per register bit
  typedef enum logic [2:0] {
    RFAT_RSVD = 3'h0,
    RFAT_RO   = 3'h1,
    RFAT_RW   = 3'h2,
    RFAT_RC   = 3'h3,
    RFAT_RW1C = 3'h4,
    RFAT_W1C  = 3'h5,
    RFAT_RW1S = 3'h6,
    RFAT_WO   = 3'h7
  } rfat_ftype_t;

  // default layout: nibbles 7..0 hold WO, RW1S, W1C, RW1C, RC, RW, RO, reserved
  localparam logic [RFAT_DW*RFAT_TW-1:0] RFAT_DEF_TYPES = {
    {4{RFAT_WO}},   {4{RFAT_RW1S}}, {4{RFAT_W1C}}, {4{RFAT_RW1C}},
    {4{RFAT_RC}},   {4{RFAT_RW}},   {4{RFAT_RO}},  {4{RFAT_RSVD}}
  };

  localparam logic [RFAT_DW-1:0] RFAT_DEF_RESET = 32'h0300_0A00;
  localparam logic [RFAT_DW-1:0] RFAT_ZERO      = 32'h0000_0000;

  typedef struct packed {
    logic               rd;
    logic               wr;
    logic [RFAT_DW-1:0] wdata;
  } rfat_req_t;

  typedef struct packed {
    logic [RFAT_DW-1:0] set;
    logic [RFAT_DW-1:0] clr;
    logic [RFAT_DW-1:0] ro;
  } rfat_hw_t;

  typedef struct packed {
    logic [RFAT_DW-1:0] value;
    logic [RFAT_DW-1:0] rdata;
    logic               rvalid;
  } rfat_state_t;

endpackage : rfat_pkg

// [rfat_bank.sv]
// Purpose: one register word whose bits each follow a chosen access kind
// Assumes: read and write strobes are one-cycle pulses on clk_sys
// Notes:   read data appears one cycle after the read strobe
//
// Behaviour
// - read-to-clear returns value, then clears it
// - read/write bits store and return written data
// - write one clears, zero keeps the bit
// - writing back read status clears only those
// - write-only clear bits clear, read as zero
// - write one sets, zero keeps, bit readable
// - write-only bits store writes, read as zero
// - every field with storage takes its reset value
// - zero reset bits clear at reset
// - one reset bits set at reset, except read-only and reserved bits
// - reserved bits read as zero
`timescale 1ns/1ps

module rfat_bank
  import rfat_pkg::*;
#(
  parameter logic [RFAT_DW*RFAT_TW-1:0] FIELD_TYPES = RFAT_DEF_TYPES,
  parameter logic [RFAT_DW-1:0]         RESET_VAL   = RFAT_DEF_RESET
) (
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  input  wire rfat_req_t          req,
  input  wire rfat_hw_t           hw_in,
  output wire logic [RFAT_DW-1:0] rdata,
  output wire logic               rvalid,
  output wire logic [RFAT_DW-1:0] field_out
);

  function automatic logic [RFAT_DW-1:0] type_mask(input rfat_ftype_t t);
    logic [RFAT_DW-1:0] m;
    m = RFAT_ZERO;
    for (int i = 0; i < RFAT_DW; i++) begin
      m[i] = (FIELD_TYPES[i*RFAT_TW +: RFAT_TW] == t);
    end
    return m;
  endfunction : type_mask

  localparam logic [RFAT_DW-1:0] M_RSVD = type_mask(RFAT_RSVD);
  localparam logic [RFAT_DW-1:0] M_RO   = type_mask(RFAT_RO);
  localparam logic [RFAT_DW-1:0] M_RW   = type_mask(RFAT_RW);
  localparam logic [RFAT_DW-1:0] M_RC   = type_mask(RFAT_RC);
  localparam logic [RFAT_DW-1:0] M_RW1C = type_mask(RFAT_RW1C);
  localparam logic [RFAT_DW-1:0] M_W1C  = type_mask(RFAT_W1C);
  localparam logic [RFAT_DW-1:0] M_RW1S = type_mask(RFAT_RW1S);
  localparam logic [RFAT_DW-1:0] M_WO   = type_mask(RFAT_WO);
  localparam logic [RFAT_DW-1:0] M_SET  = M_RC | M_RW1C | M_W1C;
  localparam logic [RFAT_DW-1:0] M_NOST = M_RO | M_RSVD;
  // no storage behind read-only and reserved bits, so they reset to zero
  localparam logic [RFAT_DW-1:0] RESET_EFF = RESET_VAL & ~M_NOST;

  // returns {next stored value, read value} for one bit
  function automatic logic [1:0] bit_eval(
    input rfat_ftype_t ft,
    input logic        cur,
    input logic        rd,
    input logic        wr,
    input logic        wd,
    input logic        hset,
    input logic        hclr,
    input logic        hro
  );
    logic nxt;
    logic rv;
    nxt = cur;
    rv  = cur;
    unique case (ft)
      RFAT_RSVD: begin
        nxt = 1'b0;
        rv  = 1'b0;
      end
      RFAT_RO: begin
        nxt = 1'b0;
        rv  = hro;
      end
      RFAT_RW: begin
        nxt = wr ? wd : cur;
      end
      RFAT_RC: begin
        // clear after read
        // hardware set wins over the read clear so no event is lost
        nxt = hset | (cur & ~rd);
      end
      RFAT_RW1C: begin
        nxt = hset | (cur & ~(wr & wd));
      end
      RFAT_W1C: begin
        nxt = hset | (cur & ~(wr & wd));
        rv  = 1'b0;
      end
      RFAT_RW1S: begin
        // one sets bit
        // software set beats a hardware clear in the same cycle
        nxt = (wr & wd) | (cur & ~hclr);
      end
      RFAT_WO: begin
        nxt = wr ? wd : cur;
        rv  = 1'b0;
      end
    endcase
    return {nxt, rv};
  endfunction : bit_eval

  rfat_state_t        state_reg;
  rfat_state_t        state_next;
  logic [RFAT_DW-1:0] bit_next;
  logic [RFAT_DW-1:0] bit_rd;

  for (genvar i = 0; i < RFAT_DW; i++) begin : g_bit
    localparam rfat_ftype_t FT = rfat_ftype_t'(FIELD_TYPES[i*RFAT_TW +: RFAT_TW]);
    assign {bit_next[i], bit_rd[i]} = bit_eval(FT, state_reg.value[i], req.rd,
                                               req.wr, req.wdata[i], hw_in.set[i],
                                               hw_in.clr[i], hw_in.ro[i]);
  end

  always_comb begin
    state_next        = state_reg;
    state_next.value  = bit_next;
    state_next.rvalid = req.rd;
    // read data holds until the next read
    if (req.rd) begin
      state_next.rdata = bit_rd;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '{value: RESET_EFF, rdata: RFAT_ZERO, rvalid: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata     = state_reg.rdata;
  assign rvalid    = state_reg.rvalid;
  assign field_out = state_reg.value;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  property p_rc_value;
    req.rd |=> ((rdata & M_RC) == ($past(state_reg.value) & M_RC));
  endproperty

  property p_rc_clear;
    req.rd |=> ((state_reg.value & M_RC & ~$past(hw_in.set)) == RFAT_ZERO);
  endproperty

  rc_read_a: assert property (p_rc_value)
    else $error("read-to-clear bit returned wrong value");

  rc_clear_a: assert property (p_rc_clear)
    else $error("read-to-clear bit not cleared by read");

  rw_store_a: assert property (
    req.wr |=> ((state_reg.value & M_RW) == ($past(req.wdata) & M_RW))
  ) else $error("read/write bit did not store write data");

  rw_readback_a: assert property (
    req.rd |=> ((rdata & M_RW) == ($past(state_reg.value) & M_RW))
  ) else $error("read/write bit read back wrong value");

  w1c_clear_a: assert property (
    req.wr |=> ((state_reg.value & (M_RW1C | M_W1C) & $past(req.wdata)
                 & ~$past(hw_in.set)) == RFAT_ZERO)
  ) else $error("write one did not clear bit");

  w1c_keep_a: assert property (
    req.wr |=> ((state_reg.value & M_RW1C & ~$past(req.wdata)) ==
                (($past(state_reg.value) | $past(hw_in.set)) & M_RW1C
                 & ~$past(req.wdata)))
  ) else $error("write zero changed a write-one-clear bit");

  sequence s_status_read;
    req.rd && !req.wr && (hw_in.set == RFAT_ZERO);
  endsequence

  status_wb_a: assert property (
    s_status_read ##1 (req.wr && req.wdata == rdata && hw_in.set == RFAT_ZERO)
    |=> ((state_reg.value & M_RW1C) == RFAT_ZERO)
  ) else $error("write-back of read status left a bit set");

  set_wins_a: assert property (
    (hw_in.set & M_SET) != RFAT_ZERO
    |=> ((state_reg.value & M_SET & $past(hw_in.set)) == ($past(hw_in.set) & M_SET))
  ) else $error("hardware set lost against a clear");

  w1c_read_a: assert property (
    req.rd |=> ((rdata & M_W1C) == RFAT_ZERO)
  ) else $error("write-only clear bit read nonzero");

  w1s_set_a: assert property (
    req.wr |=> ((state_reg.value & M_RW1S & $past(req.wdata)) ==
                ($past(req.wdata) & M_RW1S))
  ) else $error("write one did not set bit");

  w1s_keep_a: assert property (
    (req.wr && hw_in.clr == RFAT_ZERO)
    |=> ((state_reg.value & M_RW1S) ==
         (($past(state_reg.value) | $past(req.wdata)) & M_RW1S))
  ) else $error("write zero changed a write-one-set bit");

  wo_store_a: assert property (
    req.wr ##1 (!req.wr)
    |=> ((state_reg.value & M_WO) == ($past(req.wdata, 2) & M_WO))
  ) else $error("write-only bit lost its written value");

  wo_read_a: assert property (
    req.rd |=> ((rdata & M_WO) == RFAT_ZERO)
  ) else $error("write-only bit read nonzero");

  reset_val_a: assert property (
    $rose(nrst) |-> (state_reg.value == RESET_EFF && !rvalid)
  ) else $error("register not at reset value after reset");

  reset_zero_a: assert property (
    $rose(nrst) |-> ((state_reg.value & ~RESET_VAL) == RFAT_ZERO)
  ) else $error("zero-reset bit not cleared by reset");

  reset_one_a: assert property (
    $rose(nrst) |-> ((state_reg.value & RESET_EFF) == RESET_EFF)
  ) else $error("one-reset bit not set by reset");

  rsvd_read_a: assert property (
    req.rd |=> ((rdata & M_RSVD) == RFAT_ZERO)
  ) else $error("reserved bit read nonzero");

  no_store_a: assert property (
    req.wr |=> ((state_reg.value & M_NOST) == RFAT_ZERO)
  ) else $error("write stored into read-only or reserved bit");

  rc_wr_a: assert property (
    (req.wr && !req.rd)
    |=> ((state_reg.value & M_RC) ==
         (($past(state_reg.value) | $past(hw_in.set)) & M_RC))
  ) else $error("write touched a read-to-clear bit");

  rc_keep_a: assert property (
    !req.rd
    |=> ((state_reg.value & M_RC) ==
         (($past(state_reg.value) | $past(hw_in.set)) & M_RC))
  ) else $error("read-to-clear bit changed without a read");

  rw_hold_a: assert property (
    !req.wr
    |=> ((state_reg.value & (M_RW | M_WO)) == ($past(state_reg.value) & (M_RW | M_WO)))
  ) else $error("stored bit changed without a write");

  w1c_hold_a: assert property (
    !req.wr
    |=> ((state_reg.value & (M_RW1C | M_W1C)) ==
         (($past(state_reg.value) | $past(hw_in.set)) & (M_RW1C | M_W1C)))
  ) else $error("write-one-clear bit changed without a write");

  w1s_clear_a: assert property (
    (!req.wr && ((hw_in.clr & M_RW1S) != RFAT_ZERO))
    |=> ((state_reg.value & M_RW1S & $past(hw_in.clr)) == RFAT_ZERO)
  ) else $error("hardware clear missed a write-one-set bit");

  rdata_hold_a: assert property (
    !req.rd |=> (!rvalid && $stable(rdata))
  ) else $error("read data moved without a read");

  ro_read_a: assert property (
    req.rd |=> ((rdata & M_RO) == ($past(hw_in.ro) & M_RO))
  ) else $error("read-only bit did not show hardware value");

  rvalid_a: assert property (
    req.rd |=> rvalid ##1 (rvalid == $past(req.rd))
  ) else $error("read valid not one cycle after read");

  status_cycle_c: cover property (
    ((hw_in.set & M_RW1C) != RFAT_ZERO) ##1 req.rd ##1 req.wr
  );

  rc_event_c: cover property (
    req.rd && ((hw_in.set & M_RC) != RFAT_ZERO)
  );

  w1s_set_c: cover property (
    req.wr && ((req.wdata & M_RW1S) != RFAT_ZERO) ##1 req.rd
  );

  rw_round_c: cover property (
    req.wr ##1 req.rd ##1 rvalid
  );

endmodule : rfat_bank

// [rfat_bank_tb.sv]
// Purpose: self-checking bench for the register field access bank
// Assumes: default field layout and reset value from the package
// Notes:   inputs move 1 ns after the rising edge; reads wait on rvalid
`timescale 1ns/1ps

module rfat_bank_tb;
  import rfat_pkg::*;

  logic               clk_sys;
  logic               nrst;
  rfat_req_t          req;
  rfat_hw_t           hw_in;
  logic [RFAT_DW-1:0] rdata;
  logic               rvalid;
  logic [RFAT_DW-1:0] field_out;
  int                 errors;
  int                 checks_done;

  rfat_bank DUT (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .req       (req),
    .hw_in     (hw_in),
    .rdata     (rdata),
    .rvalid    (rvalid),
    .field_out (field_out)
  );

  always #2 clk_sys = ~clk_sys;

  task automatic summarize;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task automatic cmp(input string what, input logic [RFAT_DW-1:0] exp,
                     input logic [RFAT_DW-1:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp=%h got=%h", what, exp, got);
    end
  endtask : cmp

  task automatic step;
    @(posedge clk_sys);
    #1;
  endtask : step

  // one-cycle write strobe; result lands on field_out after the edge
  task automatic wr(input logic [RFAT_DW-1:0] d);
    req.wr    = 1'b1;
    req.wdata = d;
    step();
    req.wr    = 1'b0;
  endtask : wr

  // bounded wait for rvalid, then compare the returned word
  task automatic rd_chk(input logic [RFAT_DW-1:0] exp);
    int i;
    req.rd = 1'b1;
    step();
    req.rd = 1'b0;
    for (i = 0; i < 4 && rvalid !== 1'b1; i++) begin
      step();
    end
    if (rvalid !== 1'b1) begin
      errors++;
      summarize();
    end
    cmp("rdata", exp, rdata);
  endtask : rd_chk

  task automatic hw_pulse(input logic [RFAT_DW-1:0] s, input logic [RFAT_DW-1:0] c);
    hw_in.set = s;
    hw_in.clr = c;
    step();
    hw_in.set = 32'h0000_0000;
    hw_in.clr = 32'h0000_0000;
  endtask : hw_pulse

  task automatic t_reset_values;
    cmp("field_out", 32'h0300_0A00, field_out);
    rd_chk(32'h0300_0AF0);
  endtask : t_reset_values

  task automatic t_write_ones;
    wr(32'hFFFF_FF0F);
    cmp("field_out", 32'hFF00_0F00, field_out);
    rd_chk(32'h0F00_0FF0);
  endtask : t_write_ones

  task automatic t_read_clear;
    hw_pulse(32'h00F0_F000, 32'h0000_0000);
    cmp("field_out", 32'hFFF0_FF00, field_out);
    rd_chk(32'h0F00_FFF0);
    cmp("field_out", 32'hFFF0_0F00, field_out);
    wr(32'h0050_0A00);
    cmp("field_out", 32'h0FA0_0A00, field_out);
  endtask : t_read_clear

  // a status bit that arrives after the read must survive the write-back
  task automatic t_status_writeback;
    hw_pulse(32'h0005_0000, 32'h0000_0000);
    rd_chk(32'h0F05_0AF0);
    hw_pulse(32'h000A_0000, 32'h0000_0000);
    wr(32'h0F05_0A00);
    cmp("field_out", 32'h0FAA_0A00, field_out);
  endtask : t_status_writeback

  task automatic t_set_keep;
    hw_pulse(32'h0000_0000, 32'h0C00_0000);
    wr(32'h0000_0A00);
    cmp("field_out", 32'h03AA_0A00, field_out);
    rd_chk(32'h030A_0AF0);
  endtask : t_set_keep

  // read-only bits show the live input; write-back right after the read
  task automatic t_status_direct;
    hw_in.ro = 32'h0000_0050;
    rd_chk(32'h030A_0A50);
    hw_in.ro = 32'h0000_0000;
    hw_pulse(32'h0005_0000, 32'h0000_0000);
    rd_chk(32'h030F_0A00);
    wr(32'h030F_0A00);
    cmp("field_out", 32'h03A0_0A00, field_out);
    hw_in.ro = 32'hFFFF_FFFF;
  endtask : t_status_direct

  // hardware event in the read cycle: old value read, bit stays set
  task automatic t_rc_race;
    hw_in.set = 32'h0000_3000;
    req.rd    = 1'b1;
    step();
    hw_in.set = 32'h0000_0000;
    req.rd    = 1'b0;
    cmp("rvalid", 32'h0000_0001, {31'h0, rvalid});
    cmp("rdata", 32'h0300_0AF0, rdata);
    cmp("field_out", 32'h03A0_3A00, field_out);
    step();
    rd_chk(32'h0300_3AF0);
    cmp("field_out", 32'h03A0_0A00, field_out);
  endtask : t_rc_race

  task automatic t_mid_reset;
    nrst = 1'b0;
    #1;
    cmp("field_out", 32'h0300_0A00, field_out);
    cmp("rvalid", 32'h0000_0000, {31'h0, rvalid});
    step();
    nrst = 1'b1;
    step();
    rd_chk(32'h0300_0AF0);
  endtask : t_mid_reset

  initial begin
    clk_sys     = 1'b0;
    nrst        = 1'b0;
    req         = '0;
    hw_in       = '0;
    hw_in.ro    = 32'hFFFF_FFFF;
    errors      = 0;
    checks_done = 0;
    repeat (10) step();
    nrst = 1'b1;
    step();
    t_reset_values();
    t_write_ones();
    t_read_clear();
    t_status_writeback();
    t_set_keep();
    t_status_direct();
    t_rc_race();
    t_mid_reset();
    summarize();
  end

endmodule : rfat_bank_tb
